// >>> src/core_sfr_defs.svh
`ifndef CORE_SFR_DEFS_SVH
`define CORE_SFR_DEFS_SVH
// Special-function addresses
`define ADDR_IRQ_LEVEL_LOWER 8'hB8
`define ADDR_PSW 8'hD0
`define ADDR_OPERAND_A 8'hE0
`define ADDR_IRQ_ENABLE_UPPER 8'hE8
`define ADDR_IRQ_LEVEL_UPPER 8'hF8
// Reset values
`define RST_SFR 8'h00
// Status word field positions
`define PSW_CARRY 7
`define PSW_HALF_CARRY 6
`define PSW_USER0 5
`define PSW_BANK_HI 4
`define PSW_BANK_LO 3
`define PSW_OVERFLOW 2
`define PSW_USER1 1
`define PSW_PARITY 0
// Writable mask of the lower level register (bits 7:6 read zero)
`define LEVEL_LOWER_MASK 8'h3F
// Upper source numbering
`define FIRST_UPPER_SRC 6
`endif

// >>> src/core_sfr_pkg.sv
`default_nettype none
package core_sfr_pkg;
   // ALU flag update from the datapath
   typedef struct packed {
      logic carry;
      logic half_carry;
      logic overflow;
   } alu_flags_t;
   // One special-function access
   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } sfr_req_t;
   // Service state of the preemption tracker
   typedef enum logic [1:0] {
      SVC_IDLE,
      SVC_LOW,
      SVC_HIGH
   } svc_state_t;
endpackage : core_sfr_pkg
`default_nettype wire

// >>> src/parity_odd.sv
`include "core_sfr_defs.svh"
`default_nettype none
module parity_odd #(
   parameter int WIDTH = 8
) (
   // Data and parity
   input wire logic [WIDTH-1:0] data_in,
   output logic odd_out
);
   logic [WIDTH:0] chain;
   assign chain[0] = 1'b0;
   // Xor chain, one stage per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign chain[i+1] = chain[i] ^ data_in[i];
   end
   assign odd_out = chain[WIDTH];
endmodule : parity_odd
`default_nettype wire

// >>> src/core_irq_and_status_sfrs.sv
// What this block does
// R01 - Upper enable bit 1 allows, 0 blocks; bits 0..7 are sources 6..13.
// R02 - Upper enable bits 0,1,2 gate link receive, transmit done, sync field.
// R03 - Upper enable bits 3..7 gate external sources 9..13.
// R04 - Priority bit 1 means high level, 0 means low level.
// R05 - In service, only a strictly higher level may preempt.
// R06 - Lower priority bits 0..5: ext0, timer0, ext1, timer1, serial, id.
// R07 - Lower priority bits 7 and 6 are read-only zero.
// R08 - Upper priority bits 0..7 set level of sources 6..13.
// R09 - Status carry 7, half carry 6, overflow 2 from ALU, also writable.
// R10 - Status bits 5 and 1 are software flags, untouched by hardware.
// R11 - Status bits 4:3 pick working bank at 8 times the bank number.
// R12 - Status bit 0 recomputed each instruction cycle from accumulator.
// R13 - Accumulator is an ALU operand, readable and writable at 0xE0.
// R14 - Reset clears all five registers to zero.
// R15 - Global enable gates every source, upper enables included.
// R16 - Parity bit is 1 for odd count of ones in accumulator.
`include "core_sfr_defs.svh"
`default_nettype none
module core_irq_and_status_sfrs
   import core_sfr_pkg::*;
#(
   parameter int NUM_UPPER = 8,
   parameter int NUM_LOWER = 6
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // Special-function access from the core
   input wire sfr_req_t sfr_req_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_hit_out,
   // Datapath updates
   input wire logic instr_cycle_in,
   input wire logic acc_load_in,
   input wire logic [7:0] acc_value_in,
   input wire logic flags_load_in,
   input wire alu_flags_t flags_value_in,
   // Global gate from the lower enable register
   input wire logic global_irq_gate_in,
   // Interrupt sources and service handshake
   input wire logic [NUM_LOWER-1:0] lower_req_in,
   input wire logic [NUM_UPPER-1:0] upper_req_in,
   input wire logic [NUM_LOWER-1:0] lower_en_in,
   input wire logic svc_return_in,
   output logic irq_take_out,
   output logic irq_take_high_out,
   // Register contents to the core
   output logic [7:0] operand_a_out,
   output logic [7:0] psw_out,
   output logic [4:0] bank_base_out,
   output logic [NUM_UPPER-1:0] upper_gated_out
);
   logic [7:0] irq_enable_upper_bank_q;
   logic [7:0] irq_level_lower_bank_q;
   logic [7:0] irq_level_upper_bank_q;
   logic [7:0] operand_a_register_q;
   logic [7:0] psw_q;
   logic parity_now;
   logic [7:0] bit_mask;
   svc_state_t svc_q;
   logic [1:0] depth_q;

   // Decoded write strobes
   logic wr_ieu, wr_ipl, wr_ipu, wr_psw, wr_acc;
   assign wr_ieu = sfr_req_in.wr && sfr_req_in.addr == `ADDR_IRQ_ENABLE_UPPER;
   assign wr_ipl = sfr_req_in.wr && sfr_req_in.addr == `ADDR_IRQ_LEVEL_LOWER;
   assign wr_ipu = sfr_req_in.wr && sfr_req_in.addr == `ADDR_IRQ_LEVEL_UPPER;
   assign wr_psw = sfr_req_in.wr && sfr_req_in.addr == `ADDR_PSW;
   assign wr_acc = sfr_req_in.wr && sfr_req_in.addr == `ADDR_OPERAND_A;
   assign bit_mask = 8'h01 << sfr_req_in.bit_sel;

   // Bit-addressable merge: a bit op touches one bit only
   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input sfr_req_t r,
                                        input logic [7:0] m);
      logic [7:0] res;
      res = r.bit_op ? ((old_v & ~m) | (r.wdata & m)) : r.wdata;
      return res;
   endfunction : merge

   // R01 upper enable store
   // R14 every store clears on reset
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_enable_upper_bank_q <= `RST_SFR;
      end else if (wr_ieu) begin
         irq_enable_upper_bank_q <= merge(irq_enable_upper_bank_q,
                                          sfr_req_in, bit_mask);
      end
   end

   // R07 lower level store, top bits held at zero
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_level_lower_bank_q <= `RST_SFR;
      end else if (wr_ipl) begin
         irq_level_lower_bank_q <= merge(irq_level_lower_bank_q, sfr_req_in,
                                         bit_mask) & `LEVEL_LOWER_MASK;
      end
   end

   // R08 upper level store
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_level_upper_bank_q <= `RST_SFR;
      end else if (wr_ipu) begin
         irq_level_upper_bank_q <= merge(irq_level_upper_bank_q,
                                         sfr_req_in, bit_mask);
      end
   end

   // R13 accumulator; software write wins over datapath load
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         operand_a_register_q <= `RST_SFR;
      end else if (wr_acc) begin
         operand_a_register_q <= merge(operand_a_register_q,
                                       sfr_req_in, bit_mask);
      end else if (acc_load_in) begin
         operand_a_register_q <= acc_value_in;
      end
   end

   // R16 parity of the accumulator
   parity_odd #(.WIDTH(8)) u_parity (
      .data_in(operand_a_register_q),
      .odd_out(parity_now)
   );

   // Status word; ALU flags only touch 7, 6, 2, parity touches 0
   // R10 user flags move only on a software write
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         psw_q <= `RST_SFR;
      end else begin
         if (wr_psw) begin
            psw_q <= merge(psw_q, sfr_req_in, bit_mask);
         end else if (flags_load_in) begin
            // R09 ALU flag capture
            psw_q[`PSW_CARRY] <= flags_value_in.carry;
            psw_q[`PSW_HALF_CARRY] <= flags_value_in.half_carry;
            psw_q[`PSW_OVERFLOW] <= flags_value_in.overflow;
         end
         // R12 parity refresh each instruction cycle
         if (instr_cycle_in) begin
            psw_q[`PSW_PARITY] <= parity_now;
         end
      end
   end

   // R11 bank base address, 8 bytes per bank
   assign bank_base_out = {psw_q[`PSW_BANK_HI], psw_q[`PSW_BANK_LO], 3'b000};
   assign psw_out = psw_q;
   assign operand_a_out = operand_a_register_q;

   // Read mux; unmapped addresses read zero with no hit
   always_comb begin
      sfr_rdata_out = 8'h00;
      sfr_hit_out = 1'b1;
      unique case (sfr_req_in.addr)
         `ADDR_IRQ_ENABLE_UPPER: sfr_rdata_out = irq_enable_upper_bank_q;
         `ADDR_IRQ_LEVEL_LOWER: sfr_rdata_out = irq_level_lower_bank_q;
         `ADDR_IRQ_LEVEL_UPPER: sfr_rdata_out = irq_level_upper_bank_q;
         `ADDR_PSW: sfr_rdata_out = psw_q;
         `ADDR_OPERAND_A: sfr_rdata_out = operand_a_register_q;
         default: sfr_hit_out = 1'b0;
      endcase
   end

   // R02 R03 R15 per-source gating of the upper sources
   for (genvar i = 0; i < NUM_UPPER; i++) begin : g_upper
      assign upper_gated_out[i] = global_irq_gate_in &
                                  irq_enable_upper_bank_q[i] & upper_req_in[i];
   end

   // Pending by level; lower bits follow lower_en_in under the global gate
   logic [NUM_LOWER-1:0] lower_gated;
   logic pend_high, pend_low;
   assign lower_gated = lower_req_in & lower_en_in &
                        {NUM_LOWER{global_irq_gate_in}};
   // R04 R06 level split
   assign pend_high = |(lower_gated & irq_level_lower_bank_q[NUM_LOWER-1:0])
                    | |(upper_gated_out & irq_level_upper_bank_q);
   assign pend_low = |(lower_gated & ~irq_level_lower_bank_q[NUM_LOWER-1:0])
                   | |(upper_gated_out & ~irq_level_upper_bank_q);

   // R05 take only above the level in service
   always_comb begin
      irq_take_out = 1'b0;
      irq_take_high_out = 1'b0;
      unique case (svc_q)
         SVC_IDLE: begin
            irq_take_out = pend_high | pend_low;
            irq_take_high_out = pend_high;
         end
         SVC_LOW: begin
            irq_take_out = pend_high;
            irq_take_high_out = pend_high;
         end
         SVC_HIGH: begin
            irq_take_out = 1'b0;
         end
      endcase
   end

   // Service nesting; a high handler can sit on a low one
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         svc_q <= SVC_IDLE;
         depth_q <= 2'd0;
      end else if (irq_take_out) begin
         svc_q <= irq_take_high_out ? SVC_HIGH : SVC_LOW;
         depth_q <= depth_q + 2'd1;
      end else if (svc_return_in && depth_q != 2'd0) begin
         depth_q <= depth_q - 2'd1;
         svc_q <= (depth_q == 2'd2) ? SVC_LOW : SVC_IDLE;
      end
   end

   // R14 reset clears all registers
   chk_reset_clear: assert property (@(posedge clk_sys_in)
      rst_in |=> (psw_q == 8'h00 && operand_a_register_q == 8'h00 &&
                  irq_enable_upper_bank_q == 8'h00 &&
                  irq_level_lower_bank_q == 8'h00 &&
                  irq_level_upper_bank_q == 8'h00)) // R14
      else $error("register not cleared by reset");
   chk_lower_top_zero: assert property (@(posedge clk_sys_in)
      disable iff (rst_in)
      irq_level_lower_bank_q[7:6] == 2'b00) // R07
      else $error("lower level bits 7:6 not zero");
   chk_parity_follow: assert property (@(posedge clk_sys_in)
      disable iff (rst_in)
      instr_cycle_in |=> psw_q[`PSW_PARITY] == $past(^operand_a_register_q))
      else $error("parity not odd parity of accumulator"); // R12 R16
   chk_user_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !wr_psw |=> $stable({psw_q[`PSW_USER0], psw_q[`PSW_USER1]})) // R10
      else $error("user flag changed without write");
   chk_alu_carry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      flags_load_in && !wr_psw |=>
         psw_q[`PSW_CARRY] == $past(flags_value_in.carry)) // R09
      else $error("carry not captured");
   chk_bank_base: assert property (@(posedge clk_sys_in)
      disable iff (rst_in)
      bank_base_out == 5'(psw_q[4:3] * 8)) // R11
      else $error("bank base wrong");
   chk_upper_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      |upper_gated_out |-> global_irq_gate_in) // R15
      else $error("upper source passed without global gate");
   chk_no_preempt: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      svc_q == SVC_HIGH |-> !irq_take_out) // R05
      else $error("high handler preempted");
   chk_acc_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      wr_acc && !sfr_req_in.bit_op |=>
         operand_a_register_q == $past(sfr_req_in.wdata)) // R13
      else $error("accumulator write lost");
   chk_enable_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      wr_ieu && !sfr_req_in.bit_op |=>
         irq_enable_upper_bank_q == $past(sfr_req_in.wdata)) // R01
      else $error("upper enable write lost");
   chk_lower_write: assert property (@(posedge clk_sys_in) // R06
      disable iff (rst_in)
      wr_ipl && !sfr_req_in.bit_op |=>
         irq_level_lower_bank_q == ($past(sfr_req_in.wdata) & 8'h3F))
      else $error("lower level write lost");
   chk_upper_level_write: assert property (@(posedge clk_sys_in) // R08
      disable iff (rst_in)
      wr_ipu && !sfr_req_in.bit_op |=>
         irq_level_upper_bank_q == $past(sfr_req_in.wdata))
      else $error("upper level write lost");
   chk_bit_write: assert property (@(posedge clk_sys_in) // R01
      disable iff (rst_in)
      wr_ieu && sfr_req_in.bit_op |=>
         (irq_enable_upper_bank_q & ~$past(bit_mask)) ==
         ($past(irq_enable_upper_bank_q) & ~$past(bit_mask)))
      else $error("bit write touched another bit");
   chk_overflow_load: assert property (@(posedge clk_sys_in) // R09
      disable iff (rst_in)
      flags_load_in && !wr_psw |=>
         psw_q[`PSW_OVERFLOW] == $past(flags_value_in.overflow))
      else $error("overflow not captured");
   chk_half_carry_load: assert property (@(posedge clk_sys_in) // R09
      disable iff (rst_in)
      flags_load_in && !wr_psw |=>
         psw_q[`PSW_HALF_CARRY] == $past(flags_value_in.half_carry))
      else $error("half carry not captured");
   chk_take_idle: assert property (@(posedge clk_sys_in) // R05
      disable iff (rst_in)
      svc_q == SVC_IDLE && (pend_high || pend_low) |->
         irq_take_out)
      else $error("pending source not taken when idle");
   chk_acc_load: assert property (@(posedge clk_sys_in) // R13
      disable iff (rst_in)
      acc_load_in && !wr_acc |=>
         operand_a_register_q == $past(acc_value_in))
      else $error("accumulator load lost");

   cov_preempt: cover property (@(posedge clk_sys_in)
      svc_q == SVC_LOW && irq_take_high_out);
   cov_bank3: cover property (@(posedge clk_sys_in) bank_base_out == 5'h18);
   cov_bit_write: cover property (@(posedge clk_sys_in)
      wr_ieu && sfr_req_in.bit_op);
   cov_parity_odd: cover property (@(posedge clk_sys_in)
      instr_cycle_in && parity_now);
   cov_nest_return: cover property (@(posedge clk_sys_in)
      svc_return_in && depth_q == 2'd2);
endmodule : core_irq_and_status_sfrs
`default_nettype wire

// >>> dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import core_sfr_pkg::*;
   // Bench side of every port
   logic clk_sys_in, rst_in, hit, instr_cycle, acc_load, flags_load, gate;
   logic svc_return, take, take_high;
   sfr_req_t req;
   alu_flags_t flags_value;
   logic [7:0] rdata, acc_value, upper_req, operand_a, program_status_word, upper_gated;
   logic [5:0] lower_req, lower_en;
   logic [4:0] bank_base;
   int n_errors, n_tests, cycles;
   logic [7:0] addrs [5] = '{8'hB8, 8'hD0, 8'hE0, 8'hE8, 8'hF8};

   core_irq_and_status_sfrs i_core_irq_and_status_sfrs (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sfr_req_in(req),
      .sfr_rdata_out(rdata), .sfr_hit_out(hit),
      .instr_cycle_in(instr_cycle), .acc_load_in(acc_load),
      .acc_value_in(acc_value), .flags_load_in(flags_load),
      .flags_value_in(flags_value), .global_irq_gate_in(gate),
      .lower_req_in(lower_req), .upper_req_in(upper_req),
      .lower_en_in(lower_en), .svc_return_in(svc_return),
      .irq_take_out(take), .irq_take_high_out(take_high),
      .operand_a_out(operand_a), .psw_out(program_status_word),
      .bank_base_out(bank_base), .upper_gated_out(upper_gated));

   // 10 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk_sys_in);
      req.wr = 1'b0;
   endtask : sfr_write

   // Read data is combinational, so it is sampled just after the change
   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in);
      req.addr = a;
      #1;
      chk(rdata, exp, "read");
   endtask : sfr_read

   task automatic do_reset();
      @(negedge clk_sys_in);
      rst_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      rst_in = 1'b0;
   endtask : do_reset

   // Source k: 0..5 lower bank, 6..13 upper sources
   task automatic raise(input int k);
      @(negedge clk_sys_in);
      if (k < 6) lower_req = 6'(1 << k);
      else upper_req = 8'(1 << (k - 6));
      #1;
   endtask : raise

   // Drops requests and returns one handler level, so a single-level tracker goes idle
   task automatic settle();
      @(negedge clk_sys_in);
      lower_req = '0;
      upper_req = '0;
      svc_return = 1'b1;
      @(negedge clk_sys_in);
      svc_return = 1'b0;
   endtask : settle

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("MISMATCH at %0t: run did not finish", $time);
         conclude();
      end
   end

   initial begin
      rst_in = 1'b1; req = '0; instr_cycle = 0; acc_load = 0; acc_value = 0;
      flags_load = 0; flags_value = '0; gate = 0; lower_req = 0;
      lower_en = 0; upper_req = 0; svc_return = 0;
      do_reset();
      // reset values, unmapped place reads zero
      foreach (addrs[i]) sfr_read(addrs[i], 8'h00);
      sfr_read(8'hF0, 8'h00); // unmapped
      chk({7'h00, hit}, 8'h00, "hit unmapped");
      // top two level bits never stick
      sfr_write(8'hB8, 8'hFF);
      sfr_read(8'hB8, 8'h3F);
      foreach (addrs[i]) if (i > 0) sfr_write(addrs[i], 8'hFF);
      foreach (addrs[i]) if (i > 0) sfr_read(addrs[i], 8'hFF);
      sfr_write(8'hE8, 8'hA5);
      upper_req = 8'hFF;
      gate = 1'b1;
      #1 chk(upper_gated, 8'hA5, "gated");
      gate = 1'b0;
      #1 chk(upper_gated, 8'h00, "gate off");
      upper_req = 8'h00;
      // bit write sets one enable bit only
      req.bit_op = 1'b1;
      req.bit_sel = 3'h3;
      sfr_write(8'hE8, 8'hFF);
      req.bit_op = 1'b0;
      sfr_read(8'hE8, 8'hAD);
      chk({7'h00, hit}, 8'h01, "hit mapped");
      // ALU flags land, user flags untouched
      sfr_write(8'hD0, 8'h22);
      @(negedge clk_sys_in);
      flags_load = 1'b1;
      flags_value = '{carry: 1'b1, half_carry: 1'b1, overflow: 1'b1};
      @(negedge clk_sys_in);
      flags_load = 1'b0;
      chk(program_status_word, 8'hE6, "flags set");
      for (int n = 0; n < 4; n++) begin
         sfr_write(8'hD0, 8'(n << 3));
         chk({3'h0, bank_base}, 8'(n << 3), "bank");
      end
      // parity follows accumulator on each instruction cycle
      @(negedge clk_sys_in);
      acc_load = 1'b1;
      acc_value = 8'h07;
      @(negedge clk_sys_in);
      acc_load = 1'b0;
      instr_cycle = 1'b1;
      @(negedge clk_sys_in);
      instr_cycle = 1'b0;
      chk({7'h00, program_status_word[0]}, 8'h01, "odd parity");
      chk(operand_a, 8'h07, "acc load");
      sfr_write(8'hE0, 8'h03);
      instr_cycle = 1'b1;
      @(negedge clk_sys_in);
      instr_cycle = 1'b0;
      chk({7'h00, program_status_word[0]}, 8'h00, "even parity");
      sfr_read(8'hE0, 8'h03);
      // level of each of the fourteen sources
      gate = 1'b1;
      lower_en = 6'h3F;
      sfr_write(8'hE8, 8'hFF);
      for (int k = 0; k < 14; k++) begin
         sfr_write(8'hB8, 8'h00);
         sfr_write(8'hF8, 8'h00);
         raise(k);
         chk({6'h0, take, take_high}, 8'h02, "low level");
         settle();
         if (k < 6) sfr_write(8'hB8, 8'(1 << k));
         else sfr_write(8'hF8, 8'(1 << (k - 6)));
         raise(k);
         chk({6'h0, take, take_high}, 8'h03, "high level");
         settle();
      end
      // nesting: equal level waits, higher level preempts
      sfr_write(8'hF8, 8'h01);
      sfr_write(8'hB8, 8'h00);
      raise(0);
      chk({7'h00, take}, 8'h01, "low taken");
      raise(7);
      chk({7'h00, take}, 8'h00, "equal waits");
      raise(6);
      chk({6'h0, take, take_high}, 8'h03, "preempt");
      raise(6);
      chk({7'h00, take}, 8'h00, "high blocks");
      settle();
      raise(0);
      chk({7'h00, take}, 8'h00, "back to low");
      settle();
      // a second reset in mid-run clears all again
      do_reset();
      foreach (addrs[i]) sfr_read(addrs[i], 8'h00);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
